// [include/spq_if.sv]
`timescale 1ns/10ps
// ****************************************************************
// Link between host and device
// ****************************************************************
interface spq_if;
    logic sck;
    logic cs_n;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] d_out;
    logic [3:0] d_oe;
    logic [3:0] io_lvl;

    // Undriven lines read high, as with the external pull-ups.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (d_oe[i]) begin
                io_lvl[i] = d_out[i];
            end else if (h_oe[i]) begin
                io_lvl[i] = h_out[i];
            end else begin
                io_lvl[i] = 1'b1;
            end
        end
    end

    modport dev (
        input sck,
        input cs_n,
        input io_lvl,
        output d_out,
        output d_oe
    );

    modport host (
        output sck,
        output cs_n,
        output h_out,
        output h_oe,
        input io_lvl
    );
endinterface

// [include/spq_pkg.sv]
// ****************************************************************
// Shared constants, types and lane helpers
// ****************************************************************
package spq_pkg;

    // ************************************************************
    // Transfer widths
    // ************************************************************
    localparam logic [1:0] WID_SINGLE = 2'h0;
    localparam logic [1:0] WID_DUAL = 2'h1;
    localparam logic [1:0] WID_QUAD = 2'h2;

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_PERIOD_NS = 8;
    localparam int SCK_PERIOD_NS = 80;
    localparam logic [2:0] SCK_HALF_CYC =
        3'(SCK_PERIOD_NS / (2 * SYS_PERIOD_NS));

    // ************************************************************
    // Host sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LOW = 5'b00010,
        ST_HIGH = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_PAUSE = 5'b10000
    } spq_hst_e;

    // ************************************************************
    // Lane helpers
    // ************************************************************
    // A quad request without quad enable falls back to one line.
    function automatic logic [1:0] eff_width(input logic [1:0] w,
                                             input logic qe);
        if (w == WID_QUAD && !qe) begin
            return WID_SINGLE;
        end
        return w;
    endfunction

    function automatic logic [3:0] lane_step(input logic [1:0] w);
        case (w)
            WID_DUAL: return 4'h2;
            WID_QUAD: return 4'h4;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input logic [1:0] w);
        case (w)
            WID_DUAL: return 4'h3;
            WID_QUAD: return 4'hf;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                            input logic [3:0] io,
                                            input logic [1:0] w,
                                            input logic sin);
        case (w)
            WID_DUAL: return {sh[5:0], io[1:0]};
            WID_QUAD: return {sh[3:0], io};
            default: return {sh[6:0], sin};
        endcase
    endfunction

    function automatic logic [3:0] drive_bits(input logic [7:0] sh,
                                              input logic [1:0] w,
                                              input logic on_one);
        case (w)
            WID_DUAL: return {2'h0, sh[7:6]};
            WID_QUAD: return sh[7:4];
            default: return on_one ? {2'h0, sh[7], 1'h0} : {3'h0, sh[7]};
        endcase
    endfunction

endpackage

// [logic/spq_dev.sv]
`timescale 1ns/10ps
// ****************************************************************
// What this block does
// - Quad enable clear: line three pauses.
// - Quad enable set: line three carries data.
// - Host never pauses while quad enabled.
// - Pause keeps bit and byte position.
// - Pause only while chip select low.
// - Pause starts on falling edge, clock low.
// - Pause ends on rising edge, clock low.
// - Program boost only in single-line mode.
// - Sample input on rising clock when selected.
// - Change output on falling clock; float deselected.
// ****************************************************************
module spq_dev (
    // Link pins
    spq_if.dev lnk,
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire logic quad_mode_enable_bit,
    input wire logic [1:0] width_req,
    input wire logic quad_out,
    input wire logic fast_program_boost_pin,
    // Data toward the link
    input wire logic [7:0] tx_data,
    input wire logic tx_load,
    // Received data and status
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic paused,
    output logic boost_active
);

    // ************************************************************
    // Link domain declarations
    // ************************************************************
    logic qe_meta_reg;
    logic qe_reg;
    logic [1:0] wid_meta_reg;
    logic [1:0] wid_reg;
    logic qout_meta_reg;
    logic qout_reg;
    logic [1:0] wid;
    logic pause_now;
    logic [3:0] step;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] in_reg;
    logic [7:0] in_next;
    logic [7:0] out_reg;
    logic [7:0] rx_hold_reg;
    logic rx_tog_reg;
    logic byte_done;
    logic [3:0] oe_next;

    // ************************************************************
    // System domain declarations
    // ************************************************************
    logic [7:0] tx_word_reg;
    logic rx_t_meta_reg;
    logic rx_t_s1_reg;
    logic rx_t_s2_reg;
    logic pz_meta_reg;
    logic bst_meta_reg;
    logic bst_reg;

    // ************************************************************
    // Configuration brought onto the link clock
    // ************************************************************
    // The link clock only runs inside frames, so a change of mode
    // needs two link edges before it is seen; change it between
    // commands only.
    always_ff @(posedge lnk.sck or posedge rst) begin
        if (rst) begin
            qe_meta_reg <= 1'b0;
            qe_reg <= 1'b0;
            wid_meta_reg <= spq_pkg::WID_SINGLE;
            wid_reg <= spq_pkg::WID_SINGLE;
            qout_meta_reg <= 1'b0;
            qout_reg <= 1'b0;
        end else begin
            qe_meta_reg <= quad_mode_enable_bit;
            qe_reg <= qe_meta_reg;
            wid_meta_reg <= width_req;
            wid_reg <= wid_meta_reg;
            qout_meta_reg <= quad_out;
            qout_reg <= qout_meta_reg;
        end
    end

    // ************************************************************
    // Pause decode and lane arithmetic
    // ************************************************************
    always_comb begin
        wid = spq_pkg::eff_width(wid_reg, qe_reg);
        // The shifters see the pause level only on link edges, so an
        // edge made while the clock is low takes hold before the
        // next clock edge and a late edge waits for the next one.
        pause_now = !lnk.cs_n && !qe_reg && !lnk.io_lvl[3];
        step = spq_pkg::lane_step(wid);
        in_next = spq_pkg::shift_in(in_reg, lnk.io_lvl, wid,
                                    lnk.io_lvl[0]);
        cnt_next = cnt_reg + step;
        byte_done = (cnt_next == spq_pkg::BYTE_BITS);
    end

    // ************************************************************
    // Input shifter on rising link edges
    // ************************************************************
    always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            in_reg <= 8'h00;
            cnt_reg <= spq_pkg::CNT_ZERO;
        end else if (!pause_now) begin
            in_reg <= in_next;
            cnt_reg <= byte_done ? spq_pkg::CNT_ZERO : cnt_next;
        end
    end

    // A toggle marks each finished byte; the byte itself stays put
    // for at least two link edges, ample for the far side.
    always_ff @(posedge lnk.sck or posedge rst) begin
        if (rst) begin
            rx_hold_reg <= 8'h00;
            rx_tog_reg <= 1'b0;
        end else if (!lnk.cs_n && !pause_now && byte_done) begin
            rx_hold_reg <= in_next;
            rx_tog_reg <= !rx_tog_reg;
        end
    end

    // ************************************************************
    // Output shifter on falling link edges
    // ************************************************************
    // The first byte of a frame is the command, so nothing is
    // loaded for it; later bytes take the staged transmit word.
    always_ff @(negedge lnk.sck or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            out_reg <= 8'h00;
        end else if (!pause_now) begin
            if (cnt_reg == spq_pkg::CNT_ZERO) begin
                out_reg <= tx_word_reg;
            end else begin
                out_reg <= out_reg << step;
            end
        end
    end

    always_comb begin
        oe_next = 4'h0;
        if (!lnk.cs_n && !pause_now) begin
            if (wid == spq_pkg::WID_SINGLE) begin
                oe_next = 4'h2;
            end else if (qout_reg) begin
                oe_next = spq_pkg::lane_mask(wid);
            end
        end
    end

    assign lnk.d_oe = oe_next;
    assign lnk.d_out = spq_pkg::drive_bits(out_reg, wid, 1'b1);

    // ************************************************************
    // System side: transmit staging
    // ************************************************************
    // The staged word is read across domains without a handshake;
    // it must not change within three link periods of a byte end.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_word_reg <= 8'h00;
        end else if (tx_load) begin
            tx_word_reg <= tx_data;
        end
    end

    // ************************************************************
    // System side: received bytes
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_t_meta_reg <= 1'b0;
            rx_t_s1_reg <= 1'b0;
            rx_t_s2_reg <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_t_meta_reg <= rx_tog_reg;
            rx_t_s1_reg <= rx_t_meta_reg;
            rx_t_s2_reg <= rx_t_s1_reg;
            rx_valid <= rx_t_s1_reg ^ rx_t_s2_reg;
            if (rx_t_s1_reg ^ rx_t_s2_reg) begin
                rx_data <= rx_hold_reg;
            end
        end
    end

    // ************************************************************
    // System side: pause status
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pz_meta_reg <= 1'b0;
            paused <= 1'b0;
        end else begin
            pz_meta_reg <= pause_now;
            paused <= pz_meta_reg;
        end
    end

    // ************************************************************
    // System side: programming boost
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bst_meta_reg <= 1'b0;
            bst_reg <= 1'b0;
            boost_active <= 1'b0;
        end else begin
            bst_meta_reg <= fast_program_boost_pin;
            bst_reg <= bst_meta_reg;
            boost_active <= bst_reg &&
                (width_req == spq_pkg::WID_SINGLE);
        end
    end

endmodule

// [logic/spq_host.sv]
`timescale 1ns/10ps
// ****************************************************************
// Host end: makes the link clock and drives chip select
// ****************************************************************
module spq_host (
    // Link pins
    spq_if.host lnk,
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Command
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic [1:0] width,
    input wire logic drive,
    input wire logic last,
    input wire logic pause_req,
    input wire logic quad_mode_enable_bit,
    // Answer
    output logic ready,
    output logic busy,
    output logic hold_on,
    output logic [7:0] rx_byte,
    output logic rx_valid
);

    // ************************************************************
    // Declarations
    // ************************************************************
    spq_pkg::spq_hst_e st_reg;
    logic sck_reg;
    logic csn_reg;
    logic hold_n_reg;
    logic [2:0] half_reg;
    logic [3:0] cnt_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [1:0] wid_reg;
    logic drv_reg;
    logic last_reg;
    logic [1:0] wid;
    logic [3:0] step;
    logic half_end;
    logic byte_end;
    logic hold_pin;

    always_comb begin
        wid = spq_pkg::eff_width(wid_reg, quad_mode_enable_bit);
        step = spq_pkg::lane_step(wid);
        half_end = (half_reg == spq_pkg::SCK_HALF_CYC - 3'h1);
        byte_end = ((cnt_reg + step) == spq_pkg::BYTE_BITS);
        // Line three is ours to hold high only outside quad mode.
        hold_pin = !quad_mode_enable_bit;
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= spq_pkg::ST_IDLE;
            sck_reg <= 1'b0;
            csn_reg <= 1'b1;
            hold_n_reg <= 1'b1;
            half_reg <= 3'h0;
            cnt_reg <= spq_pkg::CNT_ZERO;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            wid_reg <= spq_pkg::WID_SINGLE;
            drv_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            case (st_reg)
                spq_pkg::ST_IDLE, spq_pkg::ST_WAIT: begin
                    if (start) begin
                        csn_reg <= 1'b0;
                        half_reg <= 3'h0;
                        tx_reg <= tx_byte;
                        wid_reg <= width;
                        drv_reg <= drive;
                        last_reg <= last;
                        st_reg <= spq_pkg::ST_LOW;
                    end
                end
                spq_pkg::ST_LOW: begin
                    if (pause_req && hold_pin) begin
                        hold_n_reg <= 1'b0;
                        st_reg <= spq_pkg::ST_PAUSE;
                    end else if (half_end) begin
                        half_reg <= 3'h0;
                        sck_reg <= 1'b1;
                        rx_reg <= spq_pkg::shift_in(rx_reg, lnk.io_lvl,
                                                    wid, lnk.io_lvl[1]);
                        st_reg <= spq_pkg::ST_HIGH;
                    end else begin
                        half_reg <= half_reg + 3'h1;
                    end
                end
                spq_pkg::ST_HIGH: begin
                    if (half_end) begin
                        half_reg <= 3'h0;
                        sck_reg <= 1'b0;
                        tx_reg <= tx_reg << step;
                        if (byte_end) begin
                            cnt_reg <= spq_pkg::CNT_ZERO;
                            csn_reg <= last_reg;
                            st_reg <= last_reg ? spq_pkg::ST_IDLE
                                               : spq_pkg::ST_WAIT;
                        end else begin
                            cnt_reg <= cnt_reg + step;
                            st_reg <= spq_pkg::ST_LOW;
                        end
                    end else begin
                        half_reg <= half_reg + 3'h1;
                    end
                end
                spq_pkg::ST_PAUSE: begin
                    // The clock stays low for the whole pause.
                    if (!pause_req) begin
                        hold_n_reg <= 1'b1;
                        half_reg <= 3'h0;
                        st_reg <= spq_pkg::ST_LOW;
                    end
                end
                default: begin
                    st_reg <= spq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Received bytes
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= (st_reg == spq_pkg::ST_HIGH) && half_end && byte_end;
            if ((st_reg == spq_pkg::ST_HIGH) && half_end && byte_end) begin
                rx_byte <= rx_reg;
            end
        end
    end

    // ************************************************************
    // Pins
    // ************************************************************
    always_comb begin
        lnk.h_out = spq_pkg::drive_bits(tx_reg, wid, 1'b0);
        lnk.h_oe = 4'h0;
        if (!csn_reg) begin
            if (wid == spq_pkg::WID_SINGLE) begin
                lnk.h_oe = 4'h1;
            end else if (drv_reg) begin
                lnk.h_oe = spq_pkg::lane_mask(wid);
            end
        end
        if (hold_pin) begin
            lnk.h_out[3] = hold_n_reg;
            lnk.h_oe[3] = 1'b1;
        end
    end

    assign lnk.sck = sck_reg;
    assign lnk.cs_n = csn_reg;
    assign ready = (st_reg == spq_pkg::ST_IDLE) ||
                   (st_reg == spq_pkg::ST_WAIT);
    assign busy = (st_reg != spq_pkg::ST_IDLE);
    assign hold_on = !hold_n_reg;

endmodule

// [verification/spq_chk.sv]
`timescale 1ns/10ps
// ****************************************************************
// Link checks
// ****************************************************************
module spq_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Mode
    input wire logic quad_mode_enable_bit,
    // Link signals
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] h_out,
    input wire logic [3:0] h_oe,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe,
    input wire logic [3:0] io_lvl
);
    logic held;

    // The pause line counts only while selected and not in quad mode.
    assign held = !cs_n && !quad_mode_enable_bit && !io_lvl[3];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_deselect_float: assert property (cs_n |-> d_oe == 4'h0)
        else $error("device drives while deselected");
    a_pause_float: assert property (held |-> d_oe == 4'h0)
        else $error("device drives while paused");
    a_out_on_fall: assert property (
        (!cs_n && sck && $past(sck)) |-> $stable(d_out))
        else $error("device output moved while clock high");
    a_pause_edge_low: assert property (
        (!cs_n && !quad_mode_enable_bit && $changed(io_lvl[3])) |-> !sck)
        else $error("pause line moved while clock high");
    a_pause_clock_still: assert property (held |-> !sck)
        else $error("clock ran during a pause");
    a_pause_cs_held: assert property (
        (!quad_mode_enable_bit && !io_lvl[3] && $past(held)) |-> !cs_n)
        else $error("chip select released during a pause");
    a_sck_half_period: assert property (
        $rose(sck) |-> sck [*5] ##1 !sck)
        else $error("clock high phase is not five cycles");
    a_idle_clock_low: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");
    a_line3_quad_only: assert property (
        d_oe[3] |-> quad_mode_enable_bit)
        else $error("line three driven with quad mode off");
    a_hold_quad_data: assert property (
        (quad_mode_enable_bit && h_oe[3] && !h_out[3]) |->
        (!cs_n && h_oe == 4'hf))
        else $error("host pulled line three low in quad mode");

    c_pause: cover property (held);
    c_quad_drive: cover property (d_oe[3] && !cs_n);
    c_frame_end: cover property ($rose(cs_n));
endmodule

// [verification/tb_top.sv]
`timescale 1ns/10ps
// ****************************************************************
// Host and device back to back
// ****************************************************************
module tb_top;
    logic clk_sys, rst, qe, start, drv, last, pz_req, qo, boost, tx_load;
    logic ready, busy, hold_on, h_rxv, paused, boost_act, d_rxv;
    logic [1:0] hw, dw;
    logic [7:0] tx_byte, tx_data, h_rx, d_rx, d_byte, hr, dr;
    logic [2:0] tbl [5];
    int d_cnt, mismatches, checked;

    spq_if lnk ();

    spq_host i_spq_host (.lnk(lnk), .clk_sys(clk_sys), .rst(rst),
        .start(start), .tx_byte(tx_byte), .width(hw), .drive(drv),
        .last(last), .pause_req(pz_req), .quad_mode_enable_bit(qe),
        .ready(ready), .busy(busy), .hold_on(hold_on), .rx_byte(h_rx),
        .rx_valid(h_rxv));

    spq_dev i_spq_dev (.lnk(lnk), .clk_sys(clk_sys), .rst(rst),
        .quad_mode_enable_bit(qe), .width_req(dw), .quad_out(qo),
        .fast_program_boost_pin(boost), .tx_data(tx_data),
        .tx_load(tx_load), .rx_data(d_rx), .rx_valid(d_rxv),
        .paused(paused), .boost_active(boost_act));

    spq_chk i_spq_chk (.clk_sys(clk_sys), .rst(rst),
        .quad_mode_enable_bit(qe), .sck(lnk.sck), .cs_n(lnk.cs_n),
        .h_out(lnk.h_out), .h_oe(lnk.h_oe), .d_out(lnk.d_out),
        .d_oe(lnk.d_oe), .io_lvl(lnk.io_lvl));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (d_rxv === 1'b1) begin
            d_cnt <= d_cnt + 1;
            d_byte <= d_rx;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One byte through the host port; the pause lands mid-byte.
    task automatic xfer(input logic [7:0] b, input logic [1:0] w,
                        input logic d, input logic l, input logic pz);
        int c0;
        int n;
        c0 = d_cnt;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ready !== 1'b1 && n < 300);
        chk(ready, 1'b1);
        tx_byte <= b;
        hw <= w;
        drv <= d;
        last <= l;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        if (pz) begin
            repeat (30) @(posedge clk_sys);
            pz_req <= 1'b1;
            repeat (40) @(posedge clk_sys);
            chk(paused, 1'b1);
            chk(hold_on, 1'b1);
            chk(lnk.d_oe, 4'h0);
            pz_req <= 1'b0;
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (h_rxv !== 1'b1 && n < 400);
        chk(h_rxv, 1'b1);
        hr = h_rx;
        chk(8'(d_cnt - c0), 8'h01);
        dr = d_byte;
    endtask

    // Device settings cross on link edges, so they change during a
    // throwaway one-byte frame sent at the previous width.
    task automatic frame(input logic [1:0] w, input logic q,
                         input logic [7:0] b0, input logic [7:0] b1,
                         input logic pz);
        logic ch;
        logic cd;
        ch = q || w == spq_pkg::WID_SINGLE;
        cd = !q;
        dw <= w;
        qo <= q;
        xfer(8'h00, hw, 1'b0, 1'b1, 1'b0);
        xfer(b0, w, !q, 1'b0, pz);
        if (ch) chk(hr, 8'h00);
        if (cd) chk(dr, b0);
        xfer(b1, w, !q, 1'b1, 1'b0);
        if (ch) chk(hr, tx_data);
        if (cd) chk(dr, b1);
        chk(boost_act, w == spq_pkg::WID_SINGLE);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        // Ending on a single-line frame keeps the device out of quad
        // drive when quad enable drops before the pause frame.
        tbl = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h0};
        {rst, qe, start, drv, last, pz_req, qo, boost, tx_load} = 9'h182;
        {hw, dw, tx_byte, tx_data} = '0;
        {d_cnt, d_byte, mismatches, checked} = '0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        tx_data <= 8'h96;
        tx_load <= 1'b1;
        @(posedge clk_sys);
        tx_load <= 1'b0;
        tx_data <= 8'h96;
        qe <= 1'b1;
        pz_req <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            frame(tbl[i][1:0], tbl[i][2], 8'ha5 ^ 8'(i), 8'h3c ^ 8'(i),
                  1'b0);
            chk(hold_on, 1'b0);
            chk(paused, 1'b0);
        end
        pz_req <= 1'b0;
        qe <= 1'b0;
        frame(spq_pkg::WID_SINGLE, 1'b0, 8'hc3, 8'h5e, 1'b1);
        chk(paused, 1'b0);
        boost <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(boost_act, 1'b0);
        tally_and_finish();
    end
endmodule
